// ===== design/srs_dev.sv
module srs_dev #(
   parameter int RST_CYC = srs_pkg::RST_WAIT_CYC,
   parameter int FAST_DIV = 250,
   parameter int HB_DIV = 2500,
   parameter int SMP_W = 14,
   parameter logic [7:0] CAL0 = 8'h00, // arbitrary factory values
   parameter logic [7:0] CAL1 = 8'h00,
   parameter logic [7:0] CAL2 = 8'h80,
   parameter logic [7:0] CAL3 = 8'h80
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // link
   srs_link_if.dev lk,
   // sensor side
   input wire logic addr_select_out_pin,
   input wire logic [SMP_W-1:0] smp_x,
   input wire logic [SMP_W-1:0] smp_y,
   input wire logic [SMP_W-1:0] smp_z,
   // status out
   output logic [6:0] i2c_addr,
   output logic [2:0] mode_select_field,
   output logic [7:0] range_sel,
   output logic hb_clk_sel,
   output logic int_n
);
   localparam int CW = $clog2(RST_CYC + 1);
   localparam int TW = $clog2(HB_DIV + FAST_DIV + 1);
   localparam int PW = $clog2(srs_pkg::FIFO_D);
   // async reset freezes the sync, so the strap waits until it has filled
   localparam logic [2:0] SETTLE = 3'h4;
   typedef struct packed {
      logic [7:0] rdata;
      logic ack;
      logic rst_busy;
      logic [CW-1:0] rst_cnt;
      logic addr_pend;
      logic [6:0] i2c_addr;
      logic [2:0] pin_sync;
      logic pin_lvl;
      logic [2:0] settle;
      logic [7:0] if_sel, init0f, mode, init20, init21, init28, init1a;
      logic [7:0] range, clksel, wmark, ien;
      logic [2:0][15:0] res;
      logic [2:0][11:0] cap;
      logic [1:0] push_left;
      logic drdy;
      logic [srs_pkg::FIFO_D-1:0][srs_pkg::FIFO_W-1:0] fifo;
      logic [PW-1:0] wp, rp;
      logic [PW:0] cnt;
      logic [TW-1:0] tick;
      logic int_n;
   } srs_dev_s;

   srs_dev_s st_r, st_nxt, dflt;

   // scale to the selected resolution, keeping the sign
   function automatic logic [15:0] srs_scale(input logic [SMP_W-1:0] s,
                                             input logic [1:0] res);
      logic signed [15:0] v;
      v = 16'(signed'(s));
      case (res)
         2'h0: srs_scale = 16'(v >>> 6);
         2'h1: srs_scale = 16'(v >>> 4);
         2'h2: srs_scale = 16'(v >>> 2);
         default: srs_scale = v;
      endcase
   endfunction : srs_scale

   function automatic logic [7:0] srs_cal(input logic [1:0] i);
      case (i)
         2'h0: srs_cal = CAL0;
         2'h1: srs_cal = CAL1;
         2'h2: srs_cal = CAL2;
         default: srs_cal = CAL3;
      endcase
   endfunction : srs_cal

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      dflt = '0;
      dflt.mode = {5'h00, srs_pkg::SRS_SLEEP};
      dflt.int_n = 1'b1;
      dflt.i2c_addr = srs_pkg::I2C_ADDR_LO;
      dflt.addr_pend = 1'b1;
   end

   logic do_acc, do_wr, do_rd, cfg_ok, sample, pop, push, wm_now;
   logic [7:0] rd_val;
   logic [15:0] rsel;
   logic [2:0] ax;

   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = 1'b0;
      // three-stage sync; level moves once stages two and three agree
      st_nxt.pin_sync = {st_r.pin_sync[1:0], addr_select_out_pin};
      if (st_r.pin_sync[1] == st_r.pin_sync[2]) begin
         st_nxt.pin_lvl = st_r.pin_sync[2];
      end
      // reset window: no answers until the count expires
      do_acc = lk.req && !st_r.ack && !st_r.rst_busy;
      do_wr = do_acc && lk.we;
      do_rd = do_acc && !lk.we;
      // in wake modes only the mode register and the reset command take writes
      cfg_ok = (st_r.mode[2:0] == srs_pkg::SRS_SLEEP) ||
               (st_r.mode[2:0] == srs_pkg::SRS_STANDBY);
      ax = 3'h0;
      rsel = st_r.res[0];
      if (lk.addr >= srs_pkg::A_XRES && lk.addr < srs_pkg::A_STATUS) begin
         ax = 3'(lk.addr - srs_pkg::A_XRES);
         rsel = st_r.res[ax[2:1]];
      end
      wm_now = st_r.cnt >= (PW + 1)'(st_r.wmark[PW:0]) && st_r.wmark[PW:0] != '0;
      rd_val = 8'h00;
      case (lk.addr)
         srs_pkg::A_STATUS: rd_val = {st_r.drdy, wm_now, st_r.cnt[PW], st_r.cnt == '0, 4'h0};
         srs_pkg::A_FIFO_LO: rd_val = st_r.fifo[st_r.rp][7:0];
         srs_pkg::A_FIFO_HI: rd_val = {4'h0, st_r.fifo[st_r.rp][11:8]};
         srs_pkg::A_WMARK: rd_val = st_r.wmark;
         srs_pkg::A_IEN: rd_val = st_r.ien;
         srs_pkg::A_IF_SEL: rd_val = st_r.if_sel;
         srs_pkg::A_INIT_0F: rd_val = st_r.init0f;
         srs_pkg::A_MODE: rd_val = st_r.mode;
         srs_pkg::A_CLKSEL: rd_val = st_r.clksel;
         srs_pkg::A_RANGE: rd_val = st_r.range;
         srs_pkg::A_FCNT: rd_val = 8'(st_r.cnt);
         srs_pkg::A_INIT_1A: rd_val = st_r.init1a;
         srs_pkg::A_INIT_20: rd_val = st_r.init20;
         srs_pkg::A_INIT_21: rd_val = st_r.init21;
         srs_pkg::A_INIT_28: rd_val = st_r.init28;
         default: begin
            if (lk.addr >= srs_pkg::A_XRES && lk.addr < srs_pkg::A_STATUS) begin
               rd_val = ax[0] ? rsel[15:8] : rsel[7:0];
            end else if (lk.addr >= srs_pkg::A_CAL &&
                         lk.addr < srs_pkg::A_CAL + 8'(srs_pkg::N_CAL)) begin
               rd_val = srs_cal(2'(lk.addr - srs_pkg::A_CAL));
            end
         end
      endcase
      if (do_acc) begin
         st_nxt.ack = 1'b1;
         st_nxt.rdata = do_rd ? rd_val : 8'h00;
      end
      // read-clear of data ready; a new sample below still sets it
      if (do_rd && lk.addr == srs_pkg::A_STATUS) begin
         st_nxt.drdy = 1'b0;
      end
      pop = do_rd && lk.addr == srs_pkg::A_FIFO_HI && st_r.cnt != '0;
      if (do_wr) begin
         if (lk.addr == srs_pkg::A_MODE) begin
            st_nxt.mode = lk.wdata;
         end else if (cfg_ok) begin
            case (lk.addr)
               srs_pkg::A_WMARK: st_nxt.wmark = lk.wdata;
               srs_pkg::A_IEN: st_nxt.ien = lk.wdata;
               srs_pkg::A_IF_SEL: st_nxt.if_sel = lk.wdata;
               srs_pkg::A_INIT_0F: st_nxt.init0f = lk.wdata;
               srs_pkg::A_CLKSEL: st_nxt.clksel = lk.wdata;
               srs_pkg::A_RANGE: st_nxt.range = lk.wdata;
               srs_pkg::A_INIT_1A: st_nxt.init1a = lk.wdata;
               srs_pkg::A_INIT_20: st_nxt.init20 = lk.wdata;
               srs_pkg::A_INIT_21: st_nxt.init21 = lk.wdata;
               srs_pkg::A_INIT_28: st_nxt.init28 = lk.wdata;
               default: ;
            endcase
         end
      end
      // sample timing from the selected clock, or a trigger write
      sample = 1'b0;
      if (st_r.mode[2:0] == srs_pkg::SRS_CWAKE) begin
         if (st_r.tick == '0) begin
            sample = 1'b1;
            st_nxt.tick = st_r.clksel[0] ? TW'(HB_DIV - 1) : TW'(FAST_DIV - 1);
         end else begin
            st_nxt.tick = st_r.tick - 1'b1;
         end
      end else begin
         st_nxt.tick = '0;
      end
      if (do_wr && lk.addr == srs_pkg::A_MODE && lk.wdata[srs_pkg::TRIG_BIT] &&
          lk.wdata[2:0] == srs_pkg::SRS_TRIG) begin
         sample = 1'b1;
         st_nxt.mode = {1'b0, lk.wdata[6:0]};
      end
      if (sample) begin
         st_nxt.drdy = 1'b1;
         st_nxt.res[0] = srs_scale(smp_x, st_r.range[1:0]);
         st_nxt.res[1] = srs_scale(smp_y, st_r.range[1:0]);
         st_nxt.res[2] = srs_scale(smp_z, st_r.range[1:0]);
         // heartbeat clock runs without the fifo
         if (st_r.wmark[srs_pkg::FIFO_EN_BIT] && !st_r.clksel[0]) begin
            st_nxt.cap[0] = 12'(smp_x >> (SMP_W - srs_pkg::FIFO_W));
            st_nxt.cap[1] = 12'(smp_y >> (SMP_W - srs_pkg::FIFO_W));
            st_nxt.cap[2] = 12'(smp_z >> (SMP_W - srs_pkg::FIFO_W));
            st_nxt.push_left = 2'h3;
         end
      end
      // one axis word a cycle; a full fifo drops the word
      push = 1'b0;
      if (st_r.push_left != 2'h0 && !sample) begin
         push = !st_r.cnt[PW];
         st_nxt.push_left = st_r.push_left - 1'b1;
         st_nxt.cap = {12'h000, st_r.cap[2:1]};
      end
      if (push) begin
         st_nxt.fifo[st_r.wp] = st_r.cap[0];
         st_nxt.wp = st_r.wp + 1'b1;
      end
      if (pop) begin
         st_nxt.rp = st_r.rp + 1'b1;
      end
      st_nxt.cnt = st_r.cnt + (PW + 1)'(push) - (PW + 1)'(pop);
      st_nxt.int_n = !((st_r.drdy && st_r.ien[0]) || (wm_now && st_r.ien[1]));
      if (st_r.settle != SETTLE) begin
         st_nxt.settle = st_r.settle + 1'b1;
      end
      // address strap taken once the reset window is over and the sync is full
      if (st_r.addr_pend && !st_r.rst_busy && st_r.settle == SETTLE) begin
         st_nxt.addr_pend = 1'b0;
         st_nxt.i2c_addr = st_r.pin_lvl ? srs_pkg::I2C_ADDR_HI : srs_pkg::I2C_ADDR_LO;
      end
      if (st_r.rst_busy) begin
         st_nxt.rst_cnt = st_r.rst_cnt - 1'b1;
         st_nxt.rst_busy = st_r.rst_cnt != CW'(1);
      end
      // full reset command wipes everything but the pin sampler and the current i2c address
      if (do_wr && lk.addr == srs_pkg::A_RESET && lk.wdata[srs_pkg::RESET_BIT]) begin
         st_nxt = dflt;
         st_nxt.ack = 1'b1;
         st_nxt.pin_sync = st_r.pin_sync;
         st_nxt.pin_lvl = st_r.pin_lvl;
         st_nxt.settle = st_r.settle;
         st_nxt.i2c_addr = st_r.i2c_addr;
         st_nxt.rst_busy = 1'b1;
         st_nxt.rst_cnt = CW'(RST_CYC);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '{mode: {5'h00, srs_pkg::SRS_SLEEP}, int_n: 1'b1,
                   i2c_addr: srs_pkg::I2C_ADDR_LO, addr_pend: 1'b1, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign lk.ack = st_r.ack;
   assign lk.rdata = st_r.rdata;
   assign i2c_addr = st_r.i2c_addr;
   assign mode_select_field = st_r.mode[2:0];
   assign range_sel = st_r.range;
   assign hb_clk_sel = st_r.clksel[0];
   assign int_n = st_r.int_n;
endmodule : srs_dev

// ===== design/srs_host.sv
module srs_host #(
   parameter int RST_CYC = srs_pkg::RST_WAIT_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link
   srs_link_if.host lk
);
   localparam int CW = $clog2(RST_CYC + 1);
   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_REQ = 2'b01,
      H_WAIT = 2'b10
   } srs_hstate_e;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready, pslverr;
      logic req, we;
      logic [7:0] addr, wdata, rdata;
      srs_hstate_e st;
      logic [2:0] step;
      logic single, done;
      logic [CW-1:0] wcnt;
      logic [16:0] acc;
   } srs_host_s;

   srs_host_s s_r, s_nxt;
   logic setup, wr_go, busy;
   logic [15:0] ent;

   always_comb begin
      s_nxt = s_r;
      busy = s_r.st != H_IDLE;
      setup = psel && !penable;
      wr_go = psel && penable && pwrite && s_r.pready;
      // no wait state: answer prepared in setup, taken in the first access cycle
      s_nxt.pready = setup;
      s_nxt.pslverr = 1'b0;
      if (setup) begin
         s_nxt.prdata = 32'h0000_0000;
         case (paddr)
            srs_pkg::H_CTRL: ;
            srs_pkg::H_STAT: s_nxt.prdata = {22'h0, s_r.done, busy, s_r.rdata};
            srs_pkg::H_ACC: s_nxt.prdata = {15'h0, s_r.acc};
            default: s_nxt.pslverr = 1'b1;
         endcase
      end
      ent = srs_pkg::srs_init_step(s_r.step);
      case (s_r.st)
         H_IDLE: begin
            if (wr_go && paddr == srs_pkg::H_ACC) begin
               s_nxt.acc = pwdata[16:0];
            end
            if (wr_go && paddr == srs_pkg::H_CTRL && pwdata[0]) begin
               s_nxt.st = H_REQ;
               s_nxt.step = 3'h0;
               s_nxt.single = 1'b0;
               s_nxt.done = 1'b0;
               s_nxt.req = 1'b1;
               s_nxt.we = 1'b1;
               s_nxt.addr = srs_pkg::A_MODE;
               s_nxt.wdata = srs_pkg::V_STANDBY;
            end else if (wr_go && paddr == srs_pkg::H_CTRL && pwdata[1]) begin
               s_nxt.st = H_REQ;
               s_nxt.single = 1'b1;
               s_nxt.req = 1'b1;
               s_nxt.we = s_r.acc[16];
               s_nxt.addr = s_r.acc[15:8];
               s_nxt.wdata = s_r.acc[7:0];
            end
         end
         H_REQ: begin
            if (lk.ack) begin
               s_nxt.req = 1'b0;
               s_nxt.rdata = lk.rdata;
               if (s_r.single) begin
                  s_nxt.st = H_IDLE;
               end else if (s_r.step == 3'(srs_pkg::STEP_RESET)) begin
                  s_nxt.st = H_WAIT;
                  s_nxt.wcnt = CW'(RST_CYC);
                  s_nxt.step = s_r.step + 1'b1;
               end else if (s_r.step == 3'(srs_pkg::N_INIT - 1)) begin
                  s_nxt.st = H_IDLE;
                  s_nxt.done = 1'b1;
               end else begin
                  // next table entry follows at once, in order
                  s_nxt.step = s_r.step + 1'b1;
                  s_nxt.req = 1'b1;
                  {s_nxt.addr, s_nxt.wdata} = srs_pkg::srs_init_step(s_r.step + 1'b1);
               end
            end
         end
         H_WAIT: begin
            // no link traffic at all until the full wait has run
            s_nxt.wcnt = s_r.wcnt - 1'b1;
            if (s_r.wcnt == CW'(1)) begin
               s_nxt.st = H_REQ;
               s_nxt.req = 1'b1;
               {s_nxt.addr, s_nxt.wdata} = ent;
            end
         end
         default: s_nxt.st = H_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_r <= '{st: H_IDLE, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata = s_r.prdata;
   assign pready = s_r.pready;
   assign pslverr = s_r.pslverr;
   assign lk.req = s_r.req;
   assign lk.we = s_r.we;
   assign lk.addr = s_r.addr;
   assign lk.wdata = s_r.wdata;
endmodule : srs_host

// ===== design/srs_link_if.sv
// register link: host holds req until it sees a one-cycle ack
interface srs_link_if;
   logic req;
   logic we;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic ack;
   logic [7:0] rdata;
   modport dev (input req, input we, input addr, input wdata, output ack, output rdata);
   modport host (output req, output we, output addr, output wdata, input ack, input rdata);
endinterface : srs_link_if

// ===== design/srs_pkg.sv
package srs_pkg;
   localparam int CLK_HZ = 25_000_000;
   localparam int RST_WAIT_US = 1000;
   localparam int RST_WAIT_CYC = (CLK_HZ / 1_000_000) * RST_WAIT_US;
   ////////////////////////////////////////////////////////////////////////////
   // device register offsets
   localparam logic [7:0] A_XRES = 8'h02;
   localparam logic [7:0] A_STATUS = 8'h08;
   localparam logic [7:0] A_FIFO_LO = 8'h09;
   localparam logic [7:0] A_FIFO_HI = 8'h0A;
   localparam logic [7:0] A_WMARK = 8'h0B;
   localparam logic [7:0] A_IEN = 8'h0C;
   localparam logic [7:0] A_IF_SEL = 8'h0D;
   localparam logic [7:0] A_INIT_0F = 8'h0F;
   localparam logic [7:0] A_MODE = 8'h10;
   localparam logic [7:0] A_CLKSEL = 8'h11;
   localparam logic [7:0] A_RANGE = 8'h15;
   localparam logic [7:0] A_FCNT = 8'h17;
   localparam logic [7:0] A_INIT_1A = 8'h1A;
   localparam logic [7:0] A_INIT_20 = 8'h20;
   localparam logic [7:0] A_INIT_21 = 8'h21;
   localparam logic [7:0] A_RESET = 8'h24;
   localparam logic [7:0] A_INIT_28 = 8'h28;
   localparam logic [7:0] A_CAL = 8'h30;
   localparam int N_CAL = 4;
   // values and fields
   localparam logic [7:0] V_STANDBY = 8'h01;
   localparam logic [7:0] V_RESET = 8'h40;
   localparam logic [7:0] V_I2C_EN = 8'h40;
   localparam logic [7:0] V_INIT_0F = 8'h42;
   localparam logic [7:0] V_INIT_20 = 8'h01;
   localparam logic [7:0] V_INIT_21 = 8'h80;
   localparam logic [7:0] V_ZERO = 8'h00;
   localparam int RESET_BIT = 6;
   localparam int TRIG_BIT = 7;
   localparam int FIFO_EN_BIT = 7;
   localparam logic [6:0] I2C_ADDR_LO = 7'h4C;
   localparam logic [6:0] I2C_ADDR_HI = 7'h6C;
   localparam int FIFO_W = 12;
   localparam int FIFO_D = 32;
   typedef enum logic [2:0] {
      SRS_SLEEP = 3'b000,
      SRS_STANDBY = 3'b001,
      SRS_CWAKE = 3'b101,
      SRS_TRIG = 3'b111
   } srs_mode_e;
   ////////////////////////////////////////////////////////////////////////////
   // host apb map
   localparam logic [11:0] H_CTRL = 12'h000;
   localparam logic [11:0] H_STAT = 12'h004;
   localparam logic [11:0] H_ACC = 12'h008;
   localparam int N_INIT = 8;
   localparam int STEP_RESET = 1;
   // host start-up table: address in [15:8], value in [7:0]
   function automatic logic [15:0] srs_init_step(input logic [2:0] i);
      case (i)
         3'h0: srs_init_step = {A_MODE, V_STANDBY};
         3'h1: srs_init_step = {A_RESET, V_RESET};
         3'h2: srs_init_step = {A_IF_SEL, V_I2C_EN};
         3'h3: srs_init_step = {A_INIT_0F, V_INIT_0F};
         3'h4: srs_init_step = {A_INIT_20, V_INIT_20};
         3'h5: srs_init_step = {A_INIT_21, V_INIT_21};
         3'h6: srs_init_step = {A_INIT_28, V_ZERO};
         default: srs_init_step = {A_INIT_1A, V_ZERO};
      endcase
   endfunction : srs_init_step
endpackage : srs_pkg

// ===== tb/srs_link_checker.sv
module srs_link_checker #(
   parameter int RST_CYC = 20
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // link
   input wire logic req,
   input wire logic we,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic ack,
   input wire logic [7:0] rdata
);
   logic [15:0] win_cnt;
   logic [2:0] step;
   logic sb_seen;
   wire cmd_rst = ack && req && we && addr == 8'h24 && wdata[6];
   wire wr_done = ack && req && we;
   // start-up writes expected once the reset window closes
   function automatic logic [15:0] exp_step(input logic [2:0] s);
      case (s)
         3'h1: exp_step = 16'h0D40;
         3'h2: exp_step = 16'h0F42;
         3'h3: exp_step = 16'h2001;
         3'h4: exp_step = 16'h2180;
         3'h5: exp_step = 16'h2800;
         default: exp_step = 16'h1A00;
      endcase
   endfunction : exp_step
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_cnt <= 16'h0;
         step <= 3'h0;
         sb_seen <= 1'b0;
      end else begin
         win_cnt <= cmd_rst ? 16'(RST_CYC) : (win_cnt != 16'h0) ? win_cnt - 16'h1 : win_cnt;
         // step armed at the command so an early first write is still judged
         if (cmd_rst) begin
            step <= 3'h1;
         end else if (wr_done && step != 3'h0) begin
            step <= (step == 3'h6) ? 3'h0 : step + 3'h1;
         end
         if (cmd_rst) begin
            sb_seen <= 1'b0;
         end else if (wr_done && addr == 8'h10) begin
            sb_seen <= (wdata[2:0] == 3'h1);
         end
      end
   end
   ////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   chk_req_held: assert property (req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata))
      else $error("link request changed before ack");
   chk_ack_pulse: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   chk_ack_prompt: assert property ($rose(req) |-> ##[1:2] ack)
      else $error("device did not answer a request");
   chk_ack_has_req: assert property (ack |-> req)
      else $error("ack without a request");
   chk_host_waits: assert property (win_cnt > 16'h1 |-> !req)
      else $error("request inside reset wait");
   chk_dev_silent: assert property (win_cnt != 16'h0 |-> !ack)
      else $error("ack inside reset window");
   chk_standby_first: assert property (req && we && addr == 8'h24 |-> sb_seen)
      else $error("reset command without standby");
   chk_init_order: assert property (req && step != 3'h0 |-> we && {addr, wdata} == exp_step(step))
      else $error("start-up write out of order");
   chk_if_bits: assert property (req && we && addr == 8'h0D |-> !(wdata[7] && wdata[6]))
      else $error("both interface bits set");
   cover property (cmd_rst);
   cover property (wr_done && step == 3'h6);
   cover property (ack && !we);
endmodule : srs_link_checker

// ===== tb/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RST = 20;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pin = 1'b1;
   logic [13:0] smp_x = 14'h3FFB;
   logic [13:0] smp_y = 14'h1000;
   logic [13:0] smp_z = 14'h0000;
   logic [6:0] i2c_addr;
   logic [2:0] mode_select_field;
   logic [7:0] range_sel;
   logic hb_clk_sel;
   logic int_n;
   logic [31:0] r32;
   logic err;
   logic [7:0] v;
   int n_mismatch = 0;
   int checked = 0;
   always #20 pclk = ~pclk;
   srs_link_if srs_link_if_inst ();
   srs_host #(.RST_CYC(RST)) srs_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .lk(srs_link_if_inst));
   srs_dev #(.RST_CYC(RST), .FAST_DIV(4), .CAL0(8'h11), .CAL1(8'h22),
      .CAL2(8'h33), .CAL3(8'h44)) srs_dev_inst (.pclk(pclk), .presetn(presetn),
      .lk(srs_link_if_inst), .addr_select_out_pin(pin), .smp_x(smp_x), .smp_y(smp_y),
      .smp_z(smp_z), .i2c_addr(i2c_addr), .mode_select_field(mode_select_field),
      .range_sel(range_sel), .hb_clk_sel(hb_clk_sel), .int_n(int_n));
   srs_link_checker #(.RST_CYC(RST)) srs_link_checker_inst (.pclk(pclk), .presetn(presetn),
      .req(srs_link_if_inst.req), .we(srs_link_if_inst.we), .addr(srs_link_if_inst.addr),
      .wdata(srs_link_if_inst.wdata), .ack(srs_link_if_inst.ack),
      .rdata(srs_link_if_inst.rdata));
   ////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // polls status; the bound keeps a stuck busy flag from hanging here
   task automatic wait_idle(output logic [31:0] st);
      logic e;
      int n;
      n = 0;
      do begin
         apb(1'b0, srs_pkg::H_STAT, 32'h0, st, e);
         n++;
      end while (st[8] !== 1'b0 && n < 500);
   endtask : wait_idle
   task automatic dev_acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] rv);
      logic [31:0] r;
      logic e;
      apb(1'b1, srs_pkg::H_ACC, {15'h0, w, a, d}, r, e);
      apb(1'b1, srs_pkg::H_CTRL, 32'h2, r, e);
      wait_idle(r);
      rv = r[7:0];
   endtask : dev_acc
   task automatic run_init();
      logic [31:0] r;
      logic e;
      apb(1'b1, srs_pkg::H_CTRL, 32'h1, r, e);
      wait_idle(r);
      check("init status", 32'(r[9:8]), 32'h2);
   endtask : run_init
   task automatic finish_test();
      $display("mismatches %0d checks %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      check("strap", 32'(i2c_addr), 32'h6C);
      check("mode", 32'(mode_select_field), 32'h0);
      apb(1'b0, 12'h00C, 32'h0, r32, err);
      check("unmapped err", 32'(err), 32'h1);
      check("unmapped data", r32, 32'h0);
      pin <= 1'b0;
      run_init();
      check("strap", 32'(i2c_addr), 32'h4C);
      check("mode", 32'(mode_select_field), 32'h0);
      dev_acc(1'b1, srs_pkg::A_RANGE, 8'h03, v);
      check("range", 32'(range_sel), 32'h3);
      dev_acc(1'b0, srs_pkg::A_RANGE, 8'h00, v);
      check("range rd", 32'(v), 32'h3);
      dev_acc(1'b1, srs_pkg::A_CLKSEL, 8'h01, v);
      check("hb", 32'(hb_clk_sel), 32'h1);
      dev_acc(1'b1, srs_pkg::A_CLKSEL, 8'h00, v);
      for (int i = 0; i < 4; i++) begin
         dev_acc(1'b0, 8'(srs_pkg::A_CAL + 8'(i)), 8'h00, v);
         check("cal", 32'(v), 32'({4'(i + 1), 4'(i + 1)}));
      end
      run_init();
      check("range reset", 32'(range_sel), 32'h0);
      // one manual sample with the ready interrupt enabled
      dev_acc(1'b1, srs_pkg::A_MODE, srs_pkg::V_STANDBY, v);
      dev_acc(1'b1, srs_pkg::A_IEN, 8'h01, v);
      dev_acc(1'b1, srs_pkg::A_MODE, 8'h87, v);
      repeat (10) @(posedge pclk);
      check("int", 32'(int_n), 32'h0);
      dev_acc(1'b0, 8'h03, 8'h00, v);
      check("x sign", 32'(v[7]), 32'h1);
      dev_acc(1'b0, 8'h05, 8'h00, v);
      check("y sign", 32'(v[7]), 32'h0);
      dev_acc(1'b0, srs_pkg::A_STATUS, 8'h00, v);
      check("ready", 32'(v[7]), 32'h1);
      repeat (4) @(posedge pclk);
      check("int clear", 32'(int_n), 32'h1);
      // periodic sampling into the fifo; left to fill, then the first two words read
      dev_acc(1'b1, srs_pkg::A_MODE, srs_pkg::V_STANDBY, v);
      dev_acc(1'b1, srs_pkg::A_WMARK, 8'h83, v);
      dev_acc(1'b1, srs_pkg::A_MODE, 8'h05, v);
      check("cwake", 32'(mode_select_field), 32'h5);
      repeat (60) @(posedge pclk);
      dev_acc(1'b0, srs_pkg::A_FCNT, 8'h00, v);
      check("fifo count", 32'(v), 32'h20);
      dev_acc(1'b0, srs_pkg::A_STATUS, 8'h00, v);
      check("fifo wm full", 32'(v[6:5]), 32'h3);
      dev_acc(1'b0, srs_pkg::A_FIFO_LO, 8'h00, v);
      check("fifo x lo", 32'(v), 32'hFE);
      dev_acc(1'b0, srs_pkg::A_FIFO_HI, 8'h00, v);
      check("fifo x hi", 32'(v), 32'h0F);
      dev_acc(1'b0, srs_pkg::A_FIFO_LO, 8'h00, v);
      check("fifo y lo", 32'(v), 32'h00);
      dev_acc(1'b0, srs_pkg::A_FIFO_HI, 8'h00, v);
      check("fifo y hi", 32'(v), 32'h04);
      finish_test();
   end
   initial begin
      #(40 * 30000);
      n_mismatch++;
      finish_test();
   end
endmodule : testbench
